/* File: include/wwd_pkg.sv */
// Constants and types shared by the windowed watchdog and its clock monitor
`default_nettype none

package wwd_pkg;

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [7:0] OFS_SVC = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h01;
   localparam logic [7:0] OFS_MASK = 8'h02;

   // ----------------------------------------------------------------
   // Service register layout and reset values
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] win;
      logic [4:0] key;
      logic cm;
   } wwd_svc_s;

   localparam logic [4:0] SVC_KEY = 5'h0c;
   localparam logic [1:0] WIN_RESET = 2'h3;
   localparam logic CM_RESET = 1'b1;

   // ----------------------------------------------------------------
   // Window limits in idle-timer ticks
   // ----------------------------------------------------------------
   localparam int unsigned CNT_W = 17;
   localparam logic [11:0] LOWER_LIMIT = 12'h800;
   localparam logic [16:0] UPPER_LIM_8K = 17'h02000;
   localparam logic [16:0] UPPER_LIM_16K = 17'h04000;
   localparam logic [16:0] UPPER_LIM_32K = 17'h08000;
   localparam logic [16:0] UPPER_LIM_64K = 17'h10000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned CM_GAP_NS = 100_000_000;
   localparam int unsigned CM_GAP_CYCLES = CM_GAP_NS / CLK_PERIOD_NS;
   localparam int unsigned CM_RECOVER_TICKS = 24;
   localparam logic [4:0] ERR_HOLD_CYCLES = 5'h18;

   // ----------------------------------------------------------------
   // Status and mask bit positions
   // ----------------------------------------------------------------
   localparam int unsigned EV_W = 4;
   localparam int unsigned EV_EXPIRE = 0;
   localparam int unsigned EV_EARLY = 1;
   localparam int unsigned EV_MISMATCH = 2;
   localparam int unsigned EV_CLK_FAIL = 3;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // ----------------------------------------------------------------
   // Watchdog state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      WD_OFF = 2'b00,
      WD_RUN = 2'b01,
      WD_HOLD = 2'b11
   } wwd_state_e;

endpackage

`default_nettype wire

/* File: verif/wwd_watchdog_props.sv */
// Port assertions for the windowed watchdog
`default_nettype none

module wwd_watchdog_props
   import wwd_pkg::*;
#(
   parameter int unsigned GAP_CYCLES = CM_GAP_CYCLES
) (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   // Option and time bases
   input wire logic WDOG_OPTION_EN_I,
   input wire logic INSTR_TICK_I,
   input wire logic IDLE_TICK_I,
   // Register port
   input wire logic [ADDR_W-1:0] REG_ADDR_I,
   input wire logic [DATA_W-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [DATA_W-1:0] REG_RDATA_O,
   // Error and interrupt
   input wire logic WDOG_ERR_N_O,
   input wire logic IRQ_O
);
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (RESET_I);

   // ----
   // Service steps
   // ----
   sequence svc_bad_key;
      REG_WR_I && REG_ADDR_I == OFS_SVC && REG_WDATA_I[5:1] != SVC_KEY;
   endsequence
   sequence armed;
      WDOG_OPTION_EN_I && $past(WDOG_OPTION_EN_I) && !$past(RESET_I) && WDOG_ERR_N_O && $past(WDOG_ERR_N_O);
   endsequence

   a_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
      else $error("read data not zero outside read answer");
   a_key_hidden: assert property ($past(REG_RD_I && REG_ADDR_I == OFS_SVC) |-> REG_RDATA_O[5:1] == 5'h00)
      else $error("key field visible on read");
   a_unmapped_zero: assert property ($past(REG_RD_I && REG_ADDR_I > OFS_MASK) |-> REG_RDATA_O == 8'h00)
      else $error("unmapped read not zero");
   a_option_off: assert property (!WDOG_OPTION_EN_I [*3] |-> WDOG_ERR_N_O)
      else $error("error output low with option off");
   a_err_min_low: assert property ($fell(WDOG_ERR_N_O) |-> !WDOG_ERR_N_O [*8])
      else $error("error pulse too short");
   a_bad_key_err: assert property (svc_bad_key ##0 armed |=> !WDOG_ERR_N_O)
      else $error("bad key write gave no error");
   a_reset_quiet: assert property ($fell(RESET_I) |-> WDOG_ERR_N_O && !IRQ_O && REG_RDATA_O == 8'h00)
      else $error("outputs not idle after reset");
   a_irq_cause: assert property ($rose(IRQ_O) |-> $fell(WDOG_ERR_N_O) || $past(REG_WR_I && REG_ADDR_I == OFS_MASK))
      else $error("interrupt rose without cause");
endmodule

bind wwd_watchdog wwd_watchdog_props #(.GAP_CYCLES(GAP_CYCLES)) u_props (
   .CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .WDOG_OPTION_EN_I(WDOG_OPTION_EN_I),
   .INSTR_TICK_I(INSTR_TICK_I), .IDLE_TICK_I(IDLE_TICK_I), .REG_ADDR_I(REG_ADDR_I),
   .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
   .WDOG_ERR_N_O(WDOG_ERR_N_O), .IRQ_O(IRQ_O)
);

`default_nettype wire

/* File: verif/wwd_watchdog_test.sv */
// Self-checking testbench for the windowed watchdog
`default_nettype none

module wwd_watchdog_test
   import wwd_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rst, opt_en, instr_tick, idle_tick, wr, rd, err_n, irq, instr_on;
   logic [7:0] addr, wdata, rdata;
   int fail_count, compares, idle_div;
   int cyc = 0;

   wwd_watchdog #(.GAP_CYCLES(64)) uut (
      .CORE_CLK_I(clk), .RESET_I(rst), .WDOG_OPTION_EN_I(opt_en), .INSTR_TICK_I(instr_tick),
      .IDLE_TICK_I(idle_tick), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdata), .WDOG_ERR_N_O(err_n), .IRQ_O(irq)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Time bases
   always @(posedge clk) begin
      cyc <= cyc + 1;
      instr_tick <= instr_on && cyc[1:0] == 2'h0;
      idle_tick <= (cyc % idle_div) == 0;
   end

   // ----
   // Tasks
   // ----
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      opt_en <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk8(rdata, exp);
   endtask
   task automatic test_done();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #1_000_000;
      fail_count++;
      test_done();
   end

   // ----
   // Tests
   // ----
   initial begin
      rst = 1'b1;
      opt_en = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      instr_on = 1'b1;
      idle_div = 1;
      fail_count = 0;
      compares = 0;
      do_reset();
      chk1(err_n, 1'b1);
      rd_reg(OFS_SVC, 8'hc1);
      rd_reg(8'h07, 8'h00);
      // Clock monitor armed from reset
      instr_on = 1'b0;
      cycles(100);
      chk1(err_n, 1'b0);
      rd_reg(OFS_STATUS, 8'h08);
      instr_on = 1'b1;
      cycles(200);
      chk1(err_n, 1'b1);
      wr_reg(OFS_STATUS, 8'hff);
      // Wrong key, interrupt masked then unmasked
      wr_reg(OFS_SVC, 8'h1a);
      chk1(err_n, 1'b0);
      chk1(irq, 1'b0);
      wr_reg(OFS_MASK, 8'h04);
      chk1(irq, 1'b1);
      rd_reg(OFS_MASK, 8'h04);
      wr_reg(OFS_STATUS, 8'h04);
      chk1(irq, 1'b0);
      // A service during the error hold is ignored
      wr_reg(OFS_SVC, 8'h18);
      chk1(err_n, 1'b0);
      rd_reg(OFS_SVC, 8'hc1);
      cycles(30);
      // First valid write fixes window 0, monitor off
      wr_reg(OFS_SVC, 8'h18);
      chk1(err_n, 1'b1);
      rd_reg(OFS_SVC, 8'h00);
      wr_reg(OFS_SVC, 8'hd9);
      chk1(err_n, 1'b0);
      rd_reg(OFS_SVC, 8'h00);
      cycles(30);
      wr_reg(OFS_STATUS, 8'hff);
      instr_on = 1'b0;
      cycles(2100);
      wr_reg(OFS_SVC, 8'h18);
      chk1(err_n, 1'b1);
      cycles(2030);
      wr_reg(OFS_SVC, 8'h18);
      chk1(err_n, 1'b0);
      rd_reg(OFS_STATUS, 8'h02);
      cycles(30);
      instr_on = 1'b1;
      // Option off
      @(posedge clk);
      opt_en <= 1'b0;
      wr_reg(OFS_SVC, 8'h00);
      cycles(5);
      chk1(err_n, 1'b1);
      // Each window select, and the expiry of windows 0 to 2
      for (int w = 0; w < 4; w++) begin
         idle_div = (w == 0) ? 2 : 1;
         do_reset();
         wr_reg(OFS_SVC, {w[1:0], SVC_KEY, 1'b0});
         rd_reg(OFS_SVC, {w[1:0], 6'h00});
         if (w < 3) begin
            cycles(idle_div * (8192 << w) - 12);
            chk1(err_n, 1'b1);
            cycles(20);
            chk1(err_n, 1'b0);
            rd_reg(OFS_STATUS, 8'h01);
         end
      end
      test_done();
   end
endmodule

`default_nettype wire

/* File: verilog/wwd_clk_monitor.sv */
// Instruction clock presence monitor
`default_nettype none

module wwd_clk_monitor
   import wwd_pkg::*;
#(
   parameter int unsigned GAP_CYCLES = CM_GAP_CYCLES,
   parameter int unsigned RECOVER_TICKS = CM_RECOVER_TICKS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic en_i,
   input wire logic tick_i,
   // Result
   output logic fail_o
);

   localparam int unsigned GW = $clog2(GAP_CYCLES + 1);
   localparam int unsigned RW = $clog2(RECOVER_TICKS + 1);

   logic [GW-1:0] gap_cnt;
   logic [RW-1:0] good_cnt;

   // ----------------------------------------------------------------
   // Gap measurement and recovery
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         gap_cnt <= '0;
         good_cnt <= '0;
         fail_o <= 1'b0;
      end else if (tick_i) begin
         gap_cnt <= '0;
         if (fail_o) begin
            if (good_cnt == RW'(RECOVER_TICKS - 1)) begin
               fail_o <= 1'b0;
               good_cnt <= '0;
            end else begin
               good_cnt <= good_cnt + 1'b1;
            end
         end
      end else if (gap_cnt >= GW'(GAP_CYCLES - 1)) begin
         fail_o <= 1'b1;
         good_cnt <= '0;
      end else begin
         gap_cnt <= gap_cnt + 1'b1;
      end
   end

endmodule

`default_nettype wire

/* File: verilog/wwd_watchdog.sv */
// Windowed watchdog with clock monitor, register port and interrupt
`default_nettype none

module wwd_watchdog
   import wwd_pkg::*;
#(
   parameter int unsigned GAP_CYCLES = CM_GAP_CYCLES
) (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,

   // Option and time bases
   input wire logic WDOG_OPTION_EN_I,
   input wire logic INSTR_TICK_I,
   input wire logic IDLE_TICK_I,

   // Register port
   input wire logic [ADDR_W-1:0] REG_ADDR_I,
   input wire logic [DATA_W-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [DATA_W-1:0] REG_RDATA_O,

   // Error and interrupt
   output logic WDOG_ERR_N_O,
   output logic IRQ_O
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wwd_state_e state;
   wwd_state_e next_state;
   wwd_svc_s stored;
   wwd_svc_s wr_val;
   wwd_svc_s read_view;
   logic first_done;
   logic lower_armed;
   logic [11:0] lower_cnt;
   logic lower_done;
   logic [CNT_W-1:0] upper_cnt;
   logic [CNT_W-1:0] upper_lim;
   logic [4:0] hold_cnt;
   logic hold_done;
   logic svc_wr;
   logic svc_attempt;
   logic fields_ok;
   logic svc_good;
   logic svc_bad;
   logic svc_early;
   logic expire;
   logic wd_trip;
   logic restart;
   logic cm_en;
   logic cm_fail;
   logic cm_fail_d;
   logic [EV_W-1:0] events;
   logic [EV_W-1:0] status;
   logic [EV_W-1:0] mask;
   logic in_run;
   logic status_wr;
   logic mask_wr;
   logic next_err_n;

   // ----------------------------------------------------------------
   // Register write decode
   // ----------------------------------------------------------------
   assign svc_wr = REG_WR_I && (REG_ADDR_I == OFS_SVC);
   assign status_wr = REG_WR_I && (REG_ADDR_I == OFS_STATUS);
   assign mask_wr = REG_WR_I && (REG_ADDR_I == OFS_MASK);
   assign in_run = (state == WD_RUN);
   assign wr_val = wwd_svc_s'(REG_WDATA_I);

   // Writes up to the first valid service check only the key, later writes all three fields
   always_comb begin
      if (first_done) begin
         fields_ok = (wr_val.win == stored.win) && (wr_val.key == SVC_KEY) && (wr_val.cm == stored.cm);
      end else begin
         fields_ok = (wr_val.key == SVC_KEY);
      end
   end

   // A service outside the run state, in the error hold or with the option off, is ignored
   assign svc_attempt = svc_wr && in_run;
   assign svc_early = svc_attempt && lower_armed && !lower_done;
   assign svc_bad = svc_attempt && !fields_ok;
   assign svc_good = svc_attempt && fields_ok && !svc_early;

   // ----------------------------------------------------------------
   // Upper limit decode
   // ----------------------------------------------------------------
   always_comb begin
      case (stored.win)
         2'h0: upper_lim = UPPER_LIM_8K;
         2'h1: upper_lim = UPPER_LIM_16K;
         2'h2: upper_lim = UPPER_LIM_32K;
         default: upper_lim = UPPER_LIM_64K;
      endcase
   end

   assign expire = in_run && IDLE_TICK_I && !svc_good
      && (upper_cnt >= upper_lim - 1'b1);
   assign wd_trip = expire || svc_bad || svc_early;
   assign hold_done = (hold_cnt == ERR_HOLD_CYCLES - 1'b1);
   // Both windows start over on a good service, on an error and outside the run state
   assign restart = svc_good || !in_run || wd_trip;

   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         WD_OFF: begin
            if (WDOG_OPTION_EN_I) begin
               next_state = WD_RUN;
            end
         end
         WD_RUN: begin
            if (!WDOG_OPTION_EN_I) begin
               next_state = WD_OFF;
            end else if (wd_trip) begin
               next_state = WD_HOLD;
            end
         end
         WD_HOLD: begin
            if (!WDOG_OPTION_EN_I) begin
               next_state = WD_OFF;
            end else if (hold_done) begin
               next_state = WD_RUN;
            end
         end
         default: next_state = WD_OFF;
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         state <= WD_OFF;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Error hold timer
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || state != WD_HOLD) begin
         hold_cnt <= '0;
      end else if (!hold_done) begin
         hold_cnt <= hold_cnt + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Upper limit section
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || restart) begin
         upper_cnt <= '0;
      end else if (IDLE_TICK_I) begin
         upper_cnt <= upper_cnt + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Lower limit section
   // ----------------------------------------------------------------
   assign lower_done = (lower_cnt == LOWER_LIMIT);

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || restart) begin
         lower_cnt <= '0;
      end else if (IDLE_TICK_I && !lower_done) begin
         lower_cnt <= lower_cnt + 1'b1;
      end
   end

   // The lower window guards from the first valid service after reset or option enable
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || !WDOG_OPTION_EN_I) begin
         lower_armed <= 1'b0;
      end else if (svc_good) begin
         lower_armed <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Stored window and clock monitor choice
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         stored.win <= WIN_RESET;
         stored.key <= SVC_KEY;
         stored.cm <= CM_RESET;
         first_done <= 1'b0;
      end else if (svc_good && !first_done) begin
         stored.win <= wr_val.win;
         stored.key <= SVC_KEY;
         stored.cm <= wr_val.cm;
         first_done <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Clock monitor
   // ----------------------------------------------------------------
   assign cm_en = WDOG_OPTION_EN_I && stored.cm;

   wwd_clk_monitor #(
      .GAP_CYCLES(GAP_CYCLES),
      .RECOVER_TICKS(CM_RECOVER_TICKS)
   ) u_clk_monitor (
      .clk_i(CORE_CLK_I),
      .rst_i(RESET_I),
      .en_i(cm_en),
      .tick_i(INSTR_TICK_I),
      .fail_o(cm_fail)
   );

   // Delayed copy lets only the first failing cycle raise the event
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         cm_fail_d <= 1'b0;
      end else begin
         cm_fail_d <= cm_fail;
      end
   end

   // ----------------------------------------------------------------
   // Error output
   // ----------------------------------------------------------------
   // Error hold and monitor failure both pull the output low
   always_comb begin
      next_err_n = 1'b1;
      if ((next_state == WD_HOLD) || cm_fail) begin
         next_err_n = 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         WDOG_ERR_N_O <= 1'b1;
      end else begin
         WDOG_ERR_N_O <= next_err_n;
      end
   end

   // ----------------------------------------------------------------
   // Event status and mask
   // ----------------------------------------------------------------
   always_comb begin
      events = '0;
      events[EV_EXPIRE] = expire;
      events[EV_EARLY] = svc_early && fields_ok;
      events[EV_MISMATCH] = svc_bad;
      events[EV_CLK_FAIL] = cm_fail && !cm_fail_d;
   end

   // New events win over a write-one-to-clear in the same cycle
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         status <= '0;
      end else if (status_wr) begin
         status <= (status & ~REG_WDATA_I[EV_W-1:0]) | events;
      end else begin
         status <= status | events;
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         mask <= MASK_RESET;
      end else if (mask_wr) begin
         mask <= REG_WDATA_I[EV_W-1:0];
      end
   end

   assign IRQ_O = |(status & mask);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      read_view = stored;
      read_view.key = 5'h00;
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || !REG_RD_I) begin
         REG_RDATA_O <= '0;
      end else if (REG_ADDR_I == OFS_SVC) begin
         REG_RDATA_O <= read_view;
      end else if (REG_ADDR_I == OFS_STATUS) begin
         REG_RDATA_O <= {{(DATA_W-EV_W){1'b0}}, status};
      end else if (REG_ADDR_I == OFS_MASK) begin
         REG_RDATA_O <= {{(DATA_W-EV_W){1'b0}}, mask};
      end else begin
         REG_RDATA_O <= '0;
      end
   end

endmodule

`default_nettype wire
